// file: verilog/phase_accumulator_osc.sv
/*
 * phase accumulator oscillator with an apb register slave.
 * assumes a synchronous apb master and clock sources sampled
 * as levels synchronous to pclk.
 */
// Behaviour
// [RULE_01] pulse width code gives 1..128 periods
// [RULE_02] width used only in pulse mode
// [RULE_03] software keeps width below overflow period
// [RULE_04] polarity bit inverts final output
// [RULE_05] polarity change raises interrupt when enabled
// [RULE_06] every overflow sets the flag
// [RULE_07] request needs all four enables set
// [RULE_08] flag held until software clears it
// [RULE_09] reset clears registers, increment low is one
// [RULE_10] keeps running while system sleeps
// [RULE_11] fast oscillator held on when selected; code holds it only while the module is also enabled
// [RULE_12] control bit 7 enables the module
// [RULE_13] control bit 5 shows live output
// [RULE_14] control bit 0 selects pulse mode
// [RULE_15] three-bit field selects the input clock
// [RULE_16] accumulator in three bytes, upper bits zero
// [RULE_17] accumulator bytes read live, not atomic
// [RULE_18] software does not write running accumulator
// [RULE_19] increment moves to shadow on falling edge
// [RULE_20] software writes low increment byte last
// [RULE_21] increment is upper, high, low bytes
// [RULE_22] rising edge adds increment, carry is overflow
// [RULE_23] fixed duty toggles output on overflow
// [RULE_24] pulse goes active right after overflow
// [RULE_25] disabled module loads increment at once
// [RULE_26] disabled module holds accumulator, output idle
`include "pao_defs.svh"

module phase_accumulator_osc (
    // clock, reset, clock enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // input clock sources, levels
    input  wire logic        internal_fast_oscillator,
    input  wire logic        logic_cell_one_output,
    input  wire logic        logic_cell_two_output,
    input  wire logic        logic_cell_three_output,
    input  wire logic        logic_cell_four_output,
    // results
    output logic             osc_out,
    output logic             irq_req,
    output logic             fast_osc_keep_on
);

    logic        en_q;        // module_enable
    logic        pol_q;       // output_polarity
    logic        pfm_q;       // pulse_mode_select
    logic [2:0]  pws_q;       // pulse_width_select
    logic [2:0]  cks_q;       // clock_source_select
    logic [19:0] acc_q;       // accumulator
    logic [7:0]  incl_q;      // increment_low
    logic [7:0]  inch_q;      // increment_high
    logic [3:0]  incu_q;      // increment_upper
    logic [19:0] shadow_q;    // increment_shadow
    logic        pend_q;      // low byte written, awaiting edge
    logic        src_q;       // previous source level
    logic        flag_q;      // overflow_irq_flag
    logic        ie_q;        // overflow_irq_enable
    logic        peripheral_irq_enable_q;      // peripheral_irq_enable
    logic        gie_q;       // global_irq_enable
    logic        out_q;       // output after polarity
    logic        raw_q;       // shaper output
    logic [31:0] rdata_q;     // latched read data

    logic        src;         // selected source level
    logic        tick;        // rising edge of input clock
    logic        fall;        // falling edge of input clock
    logic        carry;       // accumulator_carry
    logic [19:0] sum;         // accumulator plus increment
    logic        ovf;         // overflow strobe
    logic        wr;          // write strobe at access
    logic        rd_setup;    // read in setup phase
    logic [19:0] inc_cat;     // increment_value
    logic        irq_on;      // interrupts enabled

    // true when an offset maps to a register
    function automatic logic hit(input logic [7:0] a);
        case (a)
            `OFF_CTRL, `OFF_CLK, `OFF_ACCL, `OFF_ACCH, `OFF_ACCU,
            `OFF_INCL, `OFF_INCH, `OFF_INCU, `OFF_IRQ:
                hit = 1'b1;
            default:
                hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////
    // bus decode
    assign wr       = ce && psel && penable && pwrite && hit(paddr);
    assign rd_setup = ce && psel && !penable && !pwrite;
    assign pready   = ce;                        // zero wait states
    assign pslverr  = psel && penable && !hit(paddr);
    assign prdata   = rdata_q;

    // increment bytes, most significant first   see [RULE_21]
    assign inc_cat = {incu_q, inch_q, incl_q};
    assign irq_on  = ie_q && peripheral_irq_enable_q && gie_q;

    ////////////////////////////////////////////////////////////////
    // clock source select; reserved codes give no clock
    always_comb
    begin
        src  = 1'b0;
        tick = 1'b0;
        fall = 1'b0;
        case (cks_q)  // see [RULE_15]
            `CKS_FOSC:
            begin
                // system clock: one full period per cycle
                tick = 1'b1;
                fall = 1'b1;
            end
            `CKS_FAST:
                src = internal_fast_oscillator;
            `CKS_CELL1:
                src = logic_cell_one_output;
            `CKS_CELL2:
                src = logic_cell_two_output;
            `CKS_CELL3:
                src = logic_cell_three_output;
            `CKS_CELL4:
                src = logic_cell_four_output;
            default:
                src = 1'b0;
        endcase
        if (cks_q != `CKS_FOSC)
        begin
            tick = src && !src_q;
            fall = !src && src_q;
        end
    end

    // source edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            src_q <= 1'b0;
        else if (ce)
            src_q <= src;
    end

    ////////////////////////////////////////////////////////////////
    // adder; no sleep input, so sleep never stops it   see [RULE_10]
    assign {carry, sum} = {1'b0, acc_q} + {1'b0, shadow_q};
    assign ovf = en_q && tick && carry;  // see [RULE_22]

    // accumulator; held while disabled   see [RULE_26]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_q <= 20'h00000;
        else if (ce)
        begin
            // writes win; running writes are undefined anyway
            if (wr && paddr == `OFF_ACCL)
                acc_q[7:0] <= pwdata[7:0];
            else if (wr && paddr == `OFF_ACCH)
                acc_q[15:8] <= pwdata[7:0];
            else if (wr && paddr == `OFF_ACCU)
                acc_q[19:16] <= pwdata[3:0];
            else if (en_q && tick)
                acc_q <= sum;  // see [RULE_22]
        end
    end

    ////////////////////////////////////////////////////////////////
    // control and clock registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q  <= 1'b0;  // see [RULE_09]
            pol_q <= 1'b0;
            pfm_q <= 1'b0;
            pws_q <= 3'h0;
            cks_q <= 3'h0;
        end
        else if (wr && paddr == `OFF_CTRL)
        begin
            en_q  <= pwdata[`CTRL_EN];   // see [RULE_12]
            pol_q <= pwdata[`CTRL_POL];
            pfm_q <= pwdata[`CTRL_PFM];  // see [RULE_14]
        end
        else if (wr && paddr == `OFF_CLK)
        begin
            pws_q <= pwdata[`PWS_HI:`PWS_LO];
            cks_q <= pwdata[`CKS_HI:0];
        end
    end

    // increment registers; low byte resets to one, so a
    // freshly reset module still counts   see [RULE_09]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            incl_q <= `INCL_RST;
            inch_q <= `BYTE_ZERO;
            incu_q <= 4'h0;
        end
        else if (wr && paddr == `OFF_INCL)
            incl_q <= pwdata[7:0];
        else if (wr && paddr == `OFF_INCH)
            inch_q <= pwdata[7:0];
        else if (wr && paddr == `OFF_INCU)
            incu_q <= pwdata[3:0];
    end

    ////////////////////////////////////////////////////////////////
    // shadow transfer request; a new write wins over the edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_q <= 1'b0;
        else if (ce)
        begin
            if (wr && paddr == `OFF_INCL && en_q)
                pend_q <= 1'b1;
            else if (fall || !en_q)
                pend_q <= 1'b0;
        end
    end

    // increment shadow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shadow_q <= {12'h000, `INCL_RST};
        else if (ce)
        begin
            if (!en_q)
                shadow_q <= inc_cat;  // see [RULE_25]
            else if (pend_q && fall)
                shadow_q <= inc_cat;  // see [RULE_19]
        end
    end

    ////////////////////////////////////////////////////////////////
    // output shaping
    pulse_shaper u_shaper (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .en      (en_q),
        .pfm     (pfm_q),
        .pws     (pws_q),
        .tick    (tick),
        .ovf     (ovf),
        .raw_q   (raw_q)
    );

    // final stage: polarity   see [RULE_04]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_q <= 1'b0;
        else if (ce)
            out_q <= raw_q ^ pol_q;
    end
    assign osc_out = out_q;

    ////////////////////////////////////////////////////////////////
    // interrupt flag and enables; set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
            ie_q   <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            gie_q  <= 1'b0;
        end
        else if (ce)
        begin
            if (wr && paddr == `OFF_IRQ)
            begin
                flag_q <= pwdata[`IRQ_FLAG];  // see [RULE_08]
                ie_q   <= pwdata[`IRQ_IE];
                peripheral_irq_enable_q <= pwdata[`IRQ_PERIPHERAL_IRQ_ENABLE];
                gie_q  <= pwdata[`IRQ_GIE];
            end
            if (ovf)
                flag_q <= 1'b1;  // see [RULE_06]
            if (wr && paddr == `OFF_CTRL && irq_on
                && pwdata[`CTRL_POL] != pol_q)
                flag_q <= 1'b1;  // see [RULE_05]
        end
    end

    // request and oscillator hold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_req          <= 1'b0;
            fast_osc_keep_on <= 1'b0;
        end
        else if (ce)
        begin
            irq_req          <= flag_q && en_q && irq_on;  // see [RULE_07]
            fast_osc_keep_on <= en_q && cks_q == `CKS_FAST;  // see [RULE_11]
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data, latched in the setup phase; accumulator is live
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_q <= 32'h00000000;
        else if (rd_setup)
        begin
            case (paddr)
                `OFF_CTRL:
                    rdata_q <= {24'h000000, en_q, 1'b0, out_q, pol_q,
                                3'h0, pfm_q};  // see [RULE_13]
                `OFF_CLK:
                    rdata_q <= {24'h000000, pws_q, 2'h0, cks_q};
                `OFF_ACCL:
                    rdata_q <= {24'h000000, acc_q[7:0]};  // see [RULE_17]
                `OFF_ACCH:
                    rdata_q <= {24'h000000, acc_q[15:8]};
                `OFF_ACCU:
                    rdata_q <= {28'h0000000, acc_q[19:16]};  // see [RULE_16]
                `OFF_INCL:
                    rdata_q <= {24'h000000, incl_q};
                `OFF_INCH:
                    rdata_q <= {24'h000000, inch_q};
                `OFF_INCU:
                    rdata_q <= {28'h0000000, incu_q};
                `OFF_IRQ:
                    rdata_q <= {28'h0000000, gie_q, peripheral_irq_enable_q, ie_q, flag_q};
                default:
                    rdata_q <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    property p_ovf_flag;
        @(posedge pclk) disable iff (!presetn)
        ce && ovf |=> flag_q;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) // see [RULE_06]
        else $error("overflow did not set flag");

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        flag_q && !(wr && paddr == `OFF_IRQ) |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) // see [RULE_08]
        else $error("flag dropped without clear");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        ce && !(en_q && ie_q && peripheral_irq_enable_q && gie_q) |=> !irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // see [RULE_07]
        else $error("request without all enables");

    property p_pol;
        @(posedge pclk) disable iff (!presetn)
        ce |=> out_q == ($past(raw_q) ^ $past(pol_q));
    endproperty
    a_pol: assert property (p_pol) // see [RULE_04]
        else $error("polarity stage wrong");

    property p_add;
        @(posedge pclk) disable iff (!presetn)
        ce && en_q && tick && !wr |=> acc_q == $past(sum);
    endproperty
    a_add: assert property (p_add) // see [RULE_22]
        else $error("accumulator did not add");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !en_q && !wr |=> acc_q == $past(acc_q) && !raw_q;
    endproperty
    a_hold: assert property (p_hold) // see [RULE_26]
        else $error("disabled module moved");

    property p_dis_load;
        @(posedge pclk) disable iff (!presetn)
        ce && !en_q |=> shadow_q == $past(inc_cat);
    endproperty
    a_dis_load: assert property (p_dis_load) // see [RULE_25]
        else $error("shadow not loaded while disabled");

    property p_fall_load;
        @(posedge pclk) disable iff (!presetn)
        ce && en_q && pend_q && fall |=> shadow_q == $past(inc_cat);
    endproperty
    a_fall_load: assert property (p_fall_load) // see [RULE_19]
        else $error("shadow not loaded on falling edge");

    property p_status;
        @(posedge pclk) disable iff (!presetn)
        rd_setup && paddr == `OFF_CTRL |=> prdata[`CTRL_OUT] == $past(out_q);
    endproperty
    a_status: assert property (p_status) // see [RULE_13]
        else $error("status bit not output");

    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        ce |=> fast_osc_keep_on == ($past(en_q) && $past(cks_q) == `CKS_FAST);
    endproperty
    a_keep: assert property (p_keep) // see [RULE_11]
        else $error("fast oscillator hold wrong");

    c_pulse_ovf: cover property (@(posedge pclk) disable iff (!presetn)
        ovf && pfm_q);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        irq_req);
    c_shadow: cover property (@(posedge pclk) disable iff (!presetn)
        en_q && pend_q && fall);

endmodule

// file: verilog/pao_defs.svh
/*
 * constants of the phase accumulator oscillator: offsets, fields,
 * reset values. included by the oscillator and shaper design files and the bench top.
 */
`ifndef PAO_DEFS_SVH
`define PAO_DEFS_SVH

// register byte offsets on the bus
`define OFF_CTRL   8'h00
`define OFF_CLK    8'h04
`define OFF_ACCL   8'h08
`define OFF_ACCH   8'h0c
`define OFF_ACCU   8'h10
`define OFF_INCL   8'h14
`define OFF_INCH   8'h18
`define OFF_INCU   8'h1c
`define OFF_IRQ    8'h20

// control register fields
`define CTRL_EN    7
`define CTRL_OUT   5
`define CTRL_POL   4
`define CTRL_PFM   0

// input clock register fields
`define PWS_HI     7
`define PWS_LO     5
`define CKS_HI     2

// irq register fields
`define IRQ_FLAG   0
`define IRQ_IE     1
`define IRQ_PERIPHERAL_IRQ_ENABLE   2
`define IRQ_GIE    3

// clock source codes
`define CKS_FOSC   3'h0
`define CKS_FAST   3'h1
`define CKS_CELL1  3'h2
`define CKS_CELL2  3'h3
`define CKS_CELL3  3'h4
`define CKS_CELL4  3'h5

// reset values and accumulator width
`define INCL_RST   8'h01
`define BYTE_ZERO  8'h00
`define ACC_W      20

`endif

// file: verilog/pao_pkg.sv
/*
 * shared types of the phase accumulator oscillator.
 * assumes nothing of its surroundings.
 */
package pao_pkg;
    // pulse stretcher states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACTIVE = 2'b10
    } pulse_st_t;
endpackage

// file: verilog/pulse_shaper.sv
/*
 * output shaper: toggles on overflow or stretches a pulse.
 * assumes tick and ovf are one-cycle strobes of the input clock.
 */
`include "pao_defs.svh"

module pulse_shaper (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // control
    input  wire logic       en,
    input  wire logic       pfm,
    input  wire logic [2:0] pws,
    // input clock strobes
    input  wire logic       tick,
    input  wire logic       ovf,
    // shaped output before polarity
    output logic            raw_q
);

    pao_pkg::pulse_st_t st_q;   // stretcher state
    logic [6:0]         cnt_q;  // periods left after this one

    // periods minus one for a width code
    function automatic logic [6:0] width_m1(input logic [2:0] c);
        width_m1 = 7'((8'h01 << c) - 8'h01);
    endfunction

    ////////////////////////////////////////////////////////////////
    // shaping; disabled keeps output inactive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_q <= 1'b0;
            st_q  <= pao_pkg::ST_IDLE;
            cnt_q <= 7'h00;
        end
        else if (ce)
        begin
            if (!en)
            begin
                raw_q <= 1'b0;
                st_q  <= pao_pkg::ST_IDLE;
                cnt_q <= 7'h00;
            end
            else if (!pfm)
            begin
                // fixed duty: width ignored   see [RULE_02]
                st_q <= pao_pkg::ST_IDLE;
                if (ovf)
                    raw_q <= ~raw_q;  // see [RULE_23]
            end
            else if (ovf)
            begin
                // active from this edge   see [RULE_24]
                raw_q <= 1'b1;
                st_q  <= pao_pkg::ST_ACTIVE;
                cnt_q <= width_m1(pws);  // see [RULE_01]
            end
            else if (tick)
            begin
                case (st_q)
                    pao_pkg::ST_IDLE:
                        raw_q <= 1'b0;
                    pao_pkg::ST_ACTIVE:
                    begin
                        // width expired: back to inactive
                        if (cnt_q == 7'h00)
                        begin
                            raw_q <= 1'b0;
                            st_q  <= pao_pkg::ST_IDLE;
                        end
                        else
                            cnt_q <= cnt_q - 7'h01;
                    end
                    default:
                        st_q <= pao_pkg::ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    property p_fdc_toggle;
        @(posedge pclk) disable iff (!presetn)
        ce && en && !pfm && ovf |=> raw_q != $past(raw_q);
    endproperty
    a_fdc_toggle: assert property (p_fdc_toggle) // see [RULE_23]
        else $error("fixed duty output did not toggle");

    property p_width_load;
        @(posedge pclk) disable iff (!presetn)
        ce && en && pfm && ovf |=> raw_q && cnt_q == width_m1($past(pws));
    endproperty
    a_width_load: assert property (p_width_load) // see [RULE_01]
        else $error("pulse width not loaded");

    c_pulse_end: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == pao_pkg::ST_ACTIVE ##1 st_q == pao_pkg::ST_IDLE);

endmodule

// file: sim/osc_consumer_model.sv
/*
 * model of the peripherals that take the oscillator output and of
 * the logic cells that can clock it. assumes levels on pclk edges.
 */
module osc_consumer_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // oscillator output as the consumers see it
    input  wire logic osc_out,
    // clock source levels
    output logic      fast_osc,
    output logic      cell_one,
    output logic      cell_two,
    output logic      cell_three,
    output logic      cell_four,
    // measurements
    output int        rises,
    output int        width
);
    timeunit 1ns;
    timeprecision 1ns;
    int   run;    // cycles of the current high level
    logic last_q; // output one cycle ago

    //////////////////////////////////////////////////////////////////
    // sources idle low; only cell one is ever clocked
    initial
    begin
        fast_osc   = 1'b0;
        cell_one   = 1'b0;
        cell_two   = 1'b0;
        cell_three = 1'b0;
        cell_four  = 1'b0;
    end

    // count rises; a high pulse is reported only once it ends
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rises  <= 0;
            width  <= 0;
            run    <= 0;
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= osc_out;
            if (osc_out && !last_q)
                rises <= rises + 1;
            if (osc_out)
                run <= run + 1;
            else if (run != 0)
            begin
                width <= run;
                run   <= 0;
            end
        end
    end

    // n rising edges on cell one, one cycle high then one low
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            cell_one <= 1'b1;
            @(posedge pclk);
            cell_one <= 1'b0;
        end
    endtask
endmodule

// file: sim/phase_accumulator_oscillator_tb_top.sv
/*
 * self-checking bench of the oscillator over apb.
 * assumes zero wait states while ce is high and the consumer model.
 */
`include "pao_defs.svh"

module phase_accumulator_oscillator_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, ce, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, osc_out, irq_req, keep_on;
    logic        fast, c1, c2, c3, c4;
    int          rises, width, n_fail, compares, base;
    // rows: offset, byte written, value read back
    logic [7:0]  r_a [6] = '{`OFF_CLK, `OFF_ACCU, `OFF_INCU, `OFF_INCH, `OFF_CTRL, 8'h24};
    logic [7:0]  r_w [6] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h01, 8'hff};
    logic [7:0]  r_e [6] = '{8'he7, 8'h0f, 8'h0f, 8'ha5, 8'h01, 8'h00};

    //////////////////////////////////////////////////////////////////
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    phase_accumulator_osc dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .internal_fast_oscillator(fast), .logic_cell_one_output(c1),
        .logic_cell_two_output(c2), .logic_cell_three_output(c3),
        .logic_cell_four_output(c4), .osc_out(osc_out), .irq_req(irq_req),
        .fast_osc_keep_on(keep_on));

    osc_consumer_model peer (.pclk(pclk), .presetn(presetn), .osc_out(osc_out),
        .fast_osc(fast), .cell_one(c1), .cell_two(c2), .cell_three(c3),
        .cell_four(c4), .rises(rises), .width(width));

    //////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            n_fail++;
        end
    endtask

    // one apb transfer; idle edge first so strobes never double-assign
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 8'h00);
        chk(n, e, rd);
    endtask

    // low byte last so the shadow takes one whole value
    task automatic inc(input logic [19:0] v);
        wr(`OFF_INCU, {4'h0, v[19:16]});
        wr(`OFF_INCH, v[15:8]);
        wr(`OFF_INCL, v[7:0]);
    endtask

    //////////////////////////////////////////////////////////////////
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        n_fail = 0;
        compares = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rc("incl_rst", `OFF_INCL, 32'h01);
        rc("ctrl_rst", `OFF_CTRL, 32'h00);
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            wr(r_a[i], r_w[i]);
            rc("reg_row", r_a[i], {24'h0, r_e[i]});
            chk("slverr", {31'h0, r_a[i] == 8'h24}, {31'h0, err});
        end
        $display("test registers done");
        // accumulator written only while stopped
        wr(`OFF_CTRL, 8'h00);
        wr(`OFF_CLK, {5'h0, `CKS_CELL1});
        inc(20'h00003);
        wr(`OFF_ACCL, 8'h00);
        wr(`OFF_ACCH, 8'h00);
        wr(`OFF_ACCU, 8'h00);
        wr(`OFF_CTRL, 8'h80);
        peer.pulses(5);
        repeat (3) @(posedge pclk);
        rc("acc_low", `OFF_ACCL, 32'h0f);
        rc("acc_up", `OFF_ACCU, 32'h00);
        $display("test accumulate done");
        // half-scale increment, width code 7 must be ignored
        wr(`OFF_CTRL, 8'h00);
        wr(`OFF_CLK, 8'he0);
        inc(20'h80000);
        wr(`OFF_IRQ, 8'h0e);
        wr(`OFF_CTRL, 8'h80);
        repeat (8) @(posedge pclk);
        base = rises;
        repeat (400) @(posedge pclk);
        chk("fdc_rises", 1, {31'h0, rises - base >= 99 && rises - base <= 101});
        chk("irq_on", 1, {31'h0, irq_req});
        rc("irq_flag", `OFF_IRQ, 32'h0f);
        wr(`OFF_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        chk("irq_off", 0, {31'h0, irq_req});
        wr(`OFF_IRQ, 8'h0e);
        rc("irq_clear", `OFF_IRQ, 32'h0e);
        wr(`OFF_CLK, {5'h0, `CKS_FAST});
        wr(`OFF_CTRL, 8'h80);
        repeat (3) @(posedge pclk);
        chk("keep_on", 1, {31'h0, keep_on});
        $display("test fixed duty done");
        // overflow every 16 cycles keeps widths 1 to 8 below the period
        for (int c = 0; c < 4; c++)
        begin
            wr(`OFF_CTRL, 8'h00);
            wr(`OFF_CLK, 8'(c << 5));
            inc(20'h10000);
            wr(`OFF_CTRL, 8'h81);
            repeat (60) @(posedge pclk);
            chk("pf_width", 1 << c, width);
        end
        $display("test pulse done");
        wr(`OFF_CTRL, 8'h00);
        wr(`OFF_IRQ, 8'h0e);
        wr(`OFF_CTRL, 8'h10);
        repeat (3) @(posedge pclk);
        chk("pol_out", 1, {31'h0, osc_out});
        rc("pol_irq", `OFF_IRQ, 32'h0f);
        $display("test polarity done");
        // clock enable low stalls the bus
        ce <= 1'b0;
        @(posedge pclk);
        chk("ce_ready", 0, {31'h0, pready});
        ce <= 1'b1;
        $display("test clock enable done");
        end_of_test();
    end
endmodule
